// *** pkg/scg_regs_regs.vh ***
// Register offsets, reset values and rate limits of the sample clock generator.
// Assumes inclusion by the generator's design files and its testbench.
`ifndef SCG_REGS_REGS_VH
`define SCG_REGS_REGS_VH

// ****************************************
// Register offsets (printed values)
// ****************************************
`define SCG_OFS_RATE_REQ   16'h4E20
`define SCG_OFS_LOOP_EN    16'h4E3E
`define SCG_OFS_CLKOUT_EN  16'h4E8E
`define SCG_OFS_TERM_EN    16'h4E98
`define SCG_OFS_REF_FREQ   16'h4EAC

// ****************************************
// Reset values
// ****************************************
`define SCG_RST_RATE_REQ   32'h000F4240
`define SCG_RST_LOOP_EN    1'h1
`define SCG_RST_CLKOUT_EN  1'h0
`define SCG_RST_TERM_EN    1'h0
`define SCG_RST_REF_FREQ   32'h00000000

// ****************************************
// Frequencies in hertz
// ****************************************
`define SCG_INT_REF_HZ     32'h02625A00
`define SCG_XTAL_HZ        32'h07735940
`define SCG_MIN_RATE_HZ    32'h000003E8
`define SCG_MAX_RATE_HZ    32'h07735940
`define SCG_MAX_FIFO4_HZ   32'h03938700
`define SCG_REF_MIN_HZ     32'h000F4240
`define SCG_REF_MAX_HZ     32'h07735940

// ****************************************
// Loop model and bypass divider table
// ****************************************
`define SCG_PLL_R_SHIFT    12
`define SCG_DIV_W          44
`define SCG_DIV_CNT_W      6
`define SCG_DIV_STEPS      6'h2C
`define SCG_BYP_ENTRIES    17
`define SCG_BYP_LAST       5'h10

`endif

// *** hw/scg_div.v ***
// Sequential unsigned restoring divider, one quotient bit per enabled clock.
// Assumes the divisor is nonzero and start is pulsed only while not busy.
`timescale 1ns/100ps
`default_nettype none
`include "scg_regs_regs.vh"

module scg_div
(
    input  wire                     ref_clk,
    input  wire                     rst_b,
    input  wire                     ce,
    input  wire                     start,
    input  wire [`SCG_DIV_W-1:0]    dividend,
    input  wire [31:0]              divisor,
    output wire                     done,
    output wire [`SCG_DIV_W-1:0]    quotient
);

reg  [`SCG_DIV_W-1:0]     quo_ff;
reg  [32:0]               rem_ff;
reg  [31:0]               dvs_ff;
reg  [`SCG_DIV_CNT_W-1:0] cnt_ff;
reg                       busy_ff;
reg                       done_ff;
wire [32:0]               shifted;
wire [33:0]               trial;

assign shifted  = {rem_ff[31:0], quo_ff[`SCG_DIV_W-1]};
assign trial    = {1'b0, shifted} - {2'b00, dvs_ff};
assign done     = done_ff;
assign quotient = quo_ff;

always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        quo_ff  <= {`SCG_DIV_W{1'b0}};
        rem_ff  <= 33'h000000000;
        dvs_ff  <= 32'h00000000;
        cnt_ff  <= {`SCG_DIV_CNT_W{1'b0}};
        busy_ff <= 1'b0;
        done_ff <= 1'b0;
    end
    else if (ce)
    begin
        done_ff <= 1'b0;
        if (start && !busy_ff)
        begin
            quo_ff  <= dividend;
            rem_ff  <= 33'h000000000;
            dvs_ff  <= divisor;
            cnt_ff  <= `SCG_DIV_STEPS;
            busy_ff <= 1'b1;
        end
        else if (busy_ff)
        begin
            if (trial[33])
            begin
                rem_ff <= shifted;
                quo_ff <= {quo_ff[`SCG_DIV_W-2:0], 1'b0};
            end
            else
            begin
                rem_ff <= trial[32:0];
                quo_ff <= {quo_ff[`SCG_DIV_W-2:0], 1'b1};
            end
            cnt_ff <= cnt_ff - 1'b1;
            if (cnt_ff == {{(`SCG_DIV_CNT_W-1){1'b0}}, 1'b1})
            begin
                busy_ff <= 1'b0;
                done_ff <= 1'b1;
            end
        end
    end
end

endmodule
`default_nettype wire

// *** hw/scg_top.v ***
// Sample clock generator control: rate registers, loop/crystal setting search and
// connector control. Assumes the register port and mode inputs share ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "scg_regs_regs.vh"

// Overview of operation
// - Default: loop from internal 40 MHz reference.
// - Write requests rate; read returns nearest achievable.
// - Drive clock out when enabled and internal.
// - Never produce a rate below 1 kHz.
// - Normal mode rate at most 125 MS/s.
// - Streaming: 125 MS/s, 60 with four channels.
// - Loop enable 1 default; 0 bypasses loop.
// - Bypass: crystal over one of seventeen dividers.
// - Crystal equals highest supported sample rate.
// - Nonzero reference selects external 1-125 MHz reference.
// - Zero reference selects internal reference.
// - Loop multiplier derived from reference and request.
// - Termination only while connector is input.
module scg_top
(
    input  wire        ref_clk,
    input  wire        rst_b,
    input  wire        ce,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [15:0] reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        external_source_select,
    input  wire        fifo_mode,
    input  wire [3:0]  chan_enable,
    output wire [31:0] reg_rdata,
    output wire        reg_ack,
    output wire        rate_busy,
    output wire [31:0] pll_mult,
    output wire        pll_ext_ref_sel,
    output wire        pll_bypass,
    output wire [10:0] xtal_div,
    output wire        ext_conn_oe_b,
    output wire        ext_conn_term_en
);
localparam ST_IDLE     = 3'h0;
localparam ST_PLL_WAIT = 3'h1;
localparam ST_PLL_FIX  = 3'h2;
localparam ST_BYP_SCAN = 3'h3;

// ****************************************
// Bypass divider table
// ****************************************
function [10:0] div_tab;
    input [4:0] i;
    begin
        case (i)
            5'h00:   div_tab = 11'h001;
            5'h01:   div_tab = 11'h002;
            5'h02:   div_tab = 11'h004;
            5'h03:   div_tab = 11'h008;
            5'h04:   div_tab = 11'h00A;
            5'h05:   div_tab = 11'h010;
            5'h06:   div_tab = 11'h014;
            5'h07:   div_tab = 11'h028;
            5'h08:   div_tab = 11'h032;
            5'h09:   div_tab = 11'h050;
            5'h0A:   div_tab = 11'h064;
            5'h0B:   div_tab = 11'h0C8;
            5'h0C:   div_tab = 11'h190;
            5'h0D:   div_tab = 11'h1F4;
            5'h0E:   div_tab = 11'h320;
            5'h0F:   div_tab = 11'h3E8;
            default: div_tab = 11'h7D0;
        endcase
    end
endfunction
wire [31:0] byp_rate_w [0:`SCG_BYP_ENTRIES-1];
genvar g;
generate
    for (g = 0; g < `SCG_BYP_ENTRIES; g = g + 1)
    begin : g_byp
        localparam [4:0] IDX = g;
        assign byp_rate_w[g] = `SCG_XTAL_HZ / {21'h000000, div_tab(IDX)};
    end
endgenerate

// ****************************************
// Registers and state
// ****************************************
reg  [31:0] rate_req_ff;
reg         loop_en_ff;
reg         clkout_en_ff;
reg         term_en_ff;
reg  [31:0] ref_freq_ff;
reg  [31:0] achieved_ff;
reg  [31:0] rdata_ff;
reg         ack_ff;
reg         dirty_ff;
reg  [2:0]  st_ff;
reg  [31:0] target_ff;
reg  [31:0] max_ff;
reg  [31:0] ref_ff;
reg  [31:0] mult_ff;
reg         ext_ref_ff;
reg         bypass_ff;
reg  [10:0] xdiv_ff;
reg  [4:0]  idx_ff;
reg  [4:0]  best_idx_ff;
reg  [31:0] best_diff_ff;
reg         oe_b_ff;
reg         term_out_ff;
reg         ext_sel_prev_ff;
reg         fifo_prev_ff;
reg  [3:0]  chan_prev_ff;
reg         busy_ff;
wire        div_done;
wire [`SCG_DIV_W-1:0] div_quo;
wire        wr_rate  = reg_wr && (reg_addr == `SCG_OFS_RATE_REQ);
wire        wr_loop  = reg_wr && (reg_addr == `SCG_OFS_LOOP_EN);
wire        wr_ref   = reg_wr && (reg_addr == `SCG_OFS_REF_FREQ);
wire        mode_chg = (external_source_select != ext_sel_prev_ff) ||
                       (fifo_mode != fifo_prev_ff) || (chan_enable != chan_prev_ff);
wire        start    = dirty_ff && (st_ff == ST_IDLE);
// Event set wins over the clear taken by the start of a recomputation.
wire        nxt_dirty = wr_rate || wr_loop || wr_ref || mode_chg || (dirty_ff && !start);
wire [31:0] max_rate = (fifo_mode && (chan_enable == 4'hF)) ? `SCG_MAX_FIFO4_HZ
                                                             : `SCG_MAX_RATE_HZ;
wire [31:0] target   = (rate_req_ff < `SCG_MIN_RATE_HZ) ? `SCG_MIN_RATE_HZ :
                       (rate_req_ff > max_rate) ? max_rate : rate_req_ff;
wire        ext_ref  = (ref_freq_ff != 32'h00000000);
wire [31:0] ref_eff  = !ext_ref ? `SCG_INT_REF_HZ :
                       (ref_freq_ff < `SCG_REF_MIN_HZ) ? `SCG_REF_MIN_HZ :
                       (ref_freq_ff > `SCG_REF_MAX_HZ) ? `SCG_REF_MAX_HZ : ref_freq_ff;
// Rounded multiplier (target * 2^R + ref/2) / ref, from the same values latched at start.
wire [`SCG_DIV_W-1:0] dividend = {target, 12'h000} + {13'h0000, ref_eff[31:1]};
wire [63:0] prod     = ref_ff * mult_ff;
wire [31:0] pll_rate = prod[`SCG_PLL_R_SHIFT+31:`SCG_PLL_R_SHIFT];
wire [31:0] cur_rate = byp_rate_w[idx_ff];
wire [31:0] cur_diff = (cur_rate >= target_ff) ? cur_rate - target_ff : target_ff - cur_rate;
wire        better   = (cur_rate <= max_ff) && (cur_diff < best_diff_ff);
scg_div u_div
(
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .start    (start && loop_en_ff),
    .dividend (dividend),
    .divisor  (ref_eff),
    .done     (div_done),
    .quotient (div_quo)
);
// ****************************************
// Register port
// ****************************************
always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        rate_req_ff     <= `SCG_RST_RATE_REQ;
        loop_en_ff      <= `SCG_RST_LOOP_EN;
        clkout_en_ff    <= `SCG_RST_CLKOUT_EN;
        term_en_ff      <= `SCG_RST_TERM_EN;
        ref_freq_ff     <= `SCG_RST_REF_FREQ;
        rdata_ff        <= 32'h00000000;
        ack_ff          <= 1'b0;
        // Preloaded copies keep the first edge after reset from seeing a false change.
        ext_sel_prev_ff <= external_source_select;
        fifo_prev_ff    <= fifo_mode;
        chan_prev_ff    <= chan_enable;
    end
    else if (ce)
    begin
        ext_sel_prev_ff <= external_source_select;
        fifo_prev_ff    <= fifo_mode;
        chan_prev_ff    <= chan_enable;
        ack_ff          <= reg_wr || reg_rd;
        if (wr_rate)
            rate_req_ff <= reg_wdata;
        if (wr_loop)
            loop_en_ff <= reg_wdata[0];
        if (reg_wr && (reg_addr == `SCG_OFS_CLKOUT_EN))
            clkout_en_ff <= reg_wdata[0];
        if (reg_wr && (reg_addr == `SCG_OFS_TERM_EN))
            term_en_ff <= reg_wdata[0];
        if (wr_ref)
            ref_freq_ff <= reg_wdata;
        if (reg_rd)
        begin
            case (reg_addr)
                `SCG_OFS_RATE_REQ:  rdata_ff <= achieved_ff;
                `SCG_OFS_LOOP_EN:   rdata_ff <= {31'h00000000, loop_en_ff};
                `SCG_OFS_CLKOUT_EN: rdata_ff <= {31'h00000000, clkout_en_ff};
                `SCG_OFS_TERM_EN:   rdata_ff <= {31'h00000000, term_en_ff};
                `SCG_OFS_REF_FREQ:  rdata_ff <= ref_freq_ff;
                default:            rdata_ff <= 32'h00000000;
            endcase
        end
    end
end

// ****************************************
// Setting search
// ****************************************
always @(posedge ref_clk)
begin
    if (!rst_b)
    begin
        dirty_ff     <= 1'b1;
        busy_ff      <= 1'b1;
        st_ff        <= ST_IDLE;
        target_ff    <= 32'h00000000;
        max_ff       <= 32'h00000000;
        ref_ff       <= `SCG_INT_REF_HZ;
        mult_ff      <= 32'h00000000;
        achieved_ff  <= 32'h00000000;
        ext_ref_ff   <= 1'b0;
        bypass_ff    <= 1'b0;
        xdiv_ff      <= 11'h001;
        idx_ff       <= 5'h00;
        best_idx_ff  <= 5'h00;
        best_diff_ff <= 32'hFFFFFFFF;
        oe_b_ff      <= 1'b1;
        term_out_ff  <= 1'b0;
    end
    else if (ce)
    begin
        dirty_ff    <= nxt_dirty;
        busy_ff     <= nxt_dirty || start || (st_ff != ST_IDLE);
        oe_b_ff     <= !(clkout_en_ff && !external_source_select);
        term_out_ff <= term_en_ff && !(clkout_en_ff && !external_source_select);
        case (st_ff)
            ST_IDLE:
            begin
                if (start)
                begin
                    target_ff    <= target;
                    max_ff       <= max_rate;
                    ref_ff       <= ref_eff;
                    idx_ff       <= 5'h00;
                    best_diff_ff <= 32'hFFFFFFFF;
                    st_ff        <= loop_en_ff ? ST_PLL_WAIT : ST_BYP_SCAN;
                end
            end
            ST_PLL_WAIT:
            begin
                if (div_done)
                begin
                    mult_ff <= div_quo[31:0];
                    st_ff   <= ST_PLL_FIX;
                end
            end
            ST_PLL_FIX:
            begin
                if (pll_rate > max_ff)
                    mult_ff <= mult_ff - 32'h00000001;
                else if (pll_rate < `SCG_MIN_RATE_HZ)
                    mult_ff <= mult_ff + 32'h00000001;
                else
                begin
                    achieved_ff <= pll_rate;
                    ext_ref_ff  <= (ref_freq_ff != 32'h00000000);
                    bypass_ff   <= 1'b0;
                    st_ff       <= ST_IDLE;
                end
            end
            ST_BYP_SCAN:
            begin
                // Reference setting is never consulted here.
                if (better)
                begin
                    best_diff_ff <= cur_diff;
                    best_idx_ff  <= idx_ff;
                end
                if (idx_ff == `SCG_BYP_LAST)
                begin
                    achieved_ff <= better ? cur_rate : byp_rate_w[best_idx_ff];
                    xdiv_ff     <= div_tab(better ? idx_ff : best_idx_ff);
                    bypass_ff   <= 1'b1;
                    st_ff       <= ST_IDLE;
                end
                else
                    idx_ff <= idx_ff + 5'h01;
            end
            default:
                st_ff <= ST_IDLE;
        endcase
    end
end
assign reg_rdata        = rdata_ff;
assign reg_ack          = ack_ff;
assign rate_busy        = busy_ff;
assign pll_mult         = mult_ff;
assign pll_ext_ref_sel  = ext_ref_ff;
assign pll_bypass       = bypass_ff;
assign xtal_div         = xdiv_ff;
assign ext_conn_oe_b    = oe_b_ff;
assign ext_conn_term_en = term_out_ff;
endmodule
`default_nettype wire

// *** verif/scg_ref_src.sv ***
// Far-side model: the clock source feeding the external clock connector.
// Assumes the bench decides when the outside clock is in use.
`timescale 1ns/100ps
`default_nettype none
module scg_ref_src
#(
    parameter logic [31:0] APPLIED_HZ = 32'h00989680
)
(
    input  wire logic        drive_ext,
    output var  logic        external_source_select,
    output var  logic [31:0] applied_hz
);
    // ****************************************
    // Source behaviour
    // ****************************************
    // The frequency reported is exactly the one put on the connector.
    assign applied_hz             = APPLIED_HZ;
    assign external_source_select = drive_ext;
endmodule
`default_nettype wire

// *** verif/scg_top_asserts.sv ***
// Port-level assertions for the sample clock generator.
// Assumes one ref_clk domain; the bench drops ce only for short spells.
`timescale 1ns/100ps
`default_nettype none
module scg_top_asserts
(
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        ce,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        external_source_select,
    input wire logic        fifo_mode,
    input wire logic [3:0]  chan_enable,
    input wire logic        reg_ack,
    input wire logic        rate_busy,
    input wire logic [31:0] pll_mult,
    input wire logic        pll_ext_ref_sel,
    input wire logic        pll_bypass,
    input wire logic [10:0] xtal_div,
    input wire logic        ext_conn_oe_b,
    input wire logic        ext_conn_term_en
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic [8:0] busy_cnt_ff;
    logic       fifo4;
    assign fifo4 = fifo_mode && chan_enable == 4'hF;
    always @(posedge ref_clk)
    begin
        if (!rst_b || !rate_busy)
            busy_cnt_ff <= 9'h000;
        else if (busy_cnt_ff != 9'h1FF)
            busy_cnt_ff <= busy_cnt_ff + 9'h001;
    end
    ack_follows_req_a: assert property (ce && (reg_wr || reg_rd) |=> reg_ack)
        else $error("access not acknowledged");
    ack_has_cause_a: assert property ($rose(reg_ack) |-> $past(reg_wr || reg_rd))
        else $error("acknowledge without access");
    busy_bound_a: assert property (busy_cnt_ff < 9'h0C8)
        else $error("recomputation too long");
    settled_hold_a: assert property (!rate_busy && $past(!rate_busy) |->
        $stable(pll_mult) && $stable(pll_bypass) && $stable(xtal_div) && $stable(pll_ext_ref_sel))
        else $error("settings moved while idle");
    int_range_a: assert property (!rate_busy && !pll_bypass && !pll_ext_ref_sel |->
        pll_mult >= 32'h00000001 && pll_mult <= 32'h00003200) else $error("loop rate out of range");
    fifo4_cap_a: assert property (!rate_busy && fifo4 && $past(fifo4) |->
        (pll_bypass ? xtal_div >= 11'h004 : (pll_ext_ref_sel || pll_mult <= 32'h00001800)))
        else $error("streaming rate above limit");
    div_table_a: assert property (pll_bypass |-> xtal_div inside {11'h001, 11'h002, 11'h004,
        11'h008, 11'h00A, 11'h010, 11'h014, 11'h028, 11'h032, 11'h050, 11'h064, 11'h0C8,
        11'h190, 11'h1F4, 11'h320, 11'h3E8, 11'h7D0}) else $error("divider not in table");
    ext_no_drive_a: assert property (ce && external_source_select |=> ext_conn_oe_b)
        else $error("connector driven under outside clock");
    term_undriven_a: assert property (ext_conn_term_en |-> ext_conn_oe_b)
        else $error("termination on a driven connector");
    cover property (!rate_busy && pll_bypass);
    cover property (!rate_busy && pll_ext_ref_sel);
    cover property (!ext_conn_oe_b);
endmodule
bind scg_top scg_top_asserts i_scg_top_asserts
(
    .ref_clk, .rst_b, .ce, .reg_wr, .reg_rd, .external_source_select, .fifo_mode, .chan_enable,
    .reg_ack, .rate_busy, .pll_mult, .pll_ext_ref_sel, .pll_bypass, .xtal_div, .ext_conn_oe_b,
    .ext_conn_term_en
);
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the sample clock generator.
// Assumes the register header on the include path and a 25 MHz ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "scg_regs_regs.vh"
module testbench;
    // ****************************************
    // Signals, design and far-side model
    // ****************************************
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ce = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        drive_ext = 1'b0;
    logic        fifo_mode = 1'b0;
    logic [3:0]  chan_enable = 4'hF;
    logic        external_source_select, reg_ack, rate_busy, pll_ext_ref_sel, pll_bypass;
    logic        ext_conn_oe_b, ext_conn_term_en;
    logic [31:0] applied_hz, reg_rdata, pll_mult;
    logic [10:0] xtal_div;
    logic        loop_on = 1'b1;
    logic [31:0] ref_hz = `SCG_INT_REF_HZ;
    int          failures = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [10:0] div_tab [17] = '{11'h001, 11'h002, 11'h004, 11'h008, 11'h00A, 11'h010, 11'h014,
        11'h028, 11'h032, 11'h050, 11'h064, 11'h0C8, 11'h190, 11'h1F4, 11'h320, 11'h3E8, 11'h7D0};
    logic [15:0] rst_ofs [5] = '{`SCG_OFS_LOOP_EN, `SCG_OFS_CLKOUT_EN, `SCG_OFS_TERM_EN,
        `SCG_OFS_REF_FREQ, 16'h4E24};
    logic [31:0] corner [4] = '{32'h000001F4, 32'h000003E8, 32'h07735940, 32'h0BEBC200};

    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            failures++;
            test_done();
        end
    end

    scg_top i_scg_top (.ref_clk, .rst_b, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .external_source_select, .fifo_mode, .chan_enable, .reg_rdata, .reg_ack, .rate_busy,
        .pll_mult, .pll_ext_ref_sel, .pll_bypass, .xtal_div, .ext_conn_oe_b, .ext_conn_term_en);
    scg_ref_src i_scg_ref_src (.drive_ext, .external_source_select, .applied_hz);

    // ****************************************
    // Checks, bus cycles and expectations
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
        num_checks++;
        if (!(got === exp || (tol > 0 && (got === exp + 1 || got + 1 === exp))))
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk({31'h0, reg_ack}, 32'h1, 0);
        d = reg_rdata;
    endtask
    task automatic settle;
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while (rate_busy !== 1'b0 && n < 300);
        chk({31'h0, rate_busy}, 32'h0, 0);
    endtask
    function automatic logic [31:0] exp_mult(input logic [31:0] req, input logic [31:0] mx);
        logic [63:0] c;
        logic [63:0] m;
        c = req < `SCG_MIN_RATE_HZ ? `SCG_MIN_RATE_HZ : (req > mx ? mx : req);
        m = ((c << 12) + ref_hz / 2) / ref_hz;
        if (((m * ref_hz) >> 12) < `SCG_MIN_RATE_HZ) m++;
        if (((m * ref_hz) >> 12) > mx) m--;
        return m[31:0];
    endfunction
    function automatic logic [10:0] exp_div(input logic [31:0] req, input logic [31:0] mx);
        logic [10:0] best;
        logic [31:0] r;
        logic [31:0] be;
        best = 11'h7D0;
        be = 32'hFFFFFFFF;
        foreach (div_tab[i])
        begin
            r = `SCG_XTAL_HZ / div_tab[i];
            if (r <= mx && (r > req ? r - req : req - r) < be)
            begin
                best = div_tab[i];
                be = r > req ? r - req : req - r;
            end
        end
        return best;
    endfunction
    task automatic run_rate(input logic [31:0] req);
        logic [31:0] mx;
        logic [31:0] m;
        logic [31:0] got;
        wr(`SCG_OFS_RATE_REQ, req);
        settle();
        rd(`SCG_OFS_RATE_REQ, got);
        mx = (fifo_mode && chan_enable == 4'hF) ? `SCG_MAX_FIFO4_HZ : `SCG_MAX_RATE_HZ;
        m = exp_mult(req, mx);
        if (loop_on)
        begin
            chk(pll_mult, m, 0);
            chk({31'h0, pll_ext_ref_sel}, {31'h0, ref_hz != `SCG_INT_REF_HZ}, 0);
            chk(got, 32'(({32'h0, ref_hz} * m) >> 12), 1);
        end
        else
        begin
            chk({21'h0, xtal_div}, {21'h0, exp_div(req, mx)}, 0);
            chk(got, `SCG_XTAL_HZ / exp_div(req, mx), 0);
        end
        chk({31'h0, pll_bypass}, {31'h0, !loop_on}, 0);
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        logic [31:0] v;
        v = $urandom(32'h7230E144);
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        settle();
        chk(pll_mult, exp_mult(`SCG_RST_RATE_REQ, `SCG_MAX_RATE_HZ), 0);
        foreach (rst_ofs[i])
        begin
            rd(rst_ofs[i], v);
            chk(v, {31'h0, i == 0}, 0);
        end
        $display("test reset values done");
        foreach (corner[i])
            run_rate(corner[i]);
        repeat (6)
        begin
            wr(`SCG_OFS_RATE_REQ, $urandom_range(125000000, 1000));
            run_rate($urandom_range(125000000, 1000));
        end
        wr(`SCG_OFS_RATE_REQ, 32'h02FAF080);
        ce <= 1'b0;
        repeat (60) @(posedge ref_clk);
        #1;
        chk({31'h0, rate_busy}, 32'h1, 0);
        @(posedge ref_clk);
        ce <= 1'b1;
        run_rate(32'h02FAF080);
        $display("test loop rates done");
        @(posedge ref_clk);
        fifo_mode <= 1'b1;
        run_rate(32'h05F5E100);
        @(posedge ref_clk);
        chan_enable <= 4'h3;
        run_rate(32'h07735940);
        @(posedge ref_clk);
        fifo_mode <= 1'b0;
        chan_enable <= 4'hF;
        run_rate(32'h07735940);
        $display("test channel limits done");
        wr(`SCG_OFS_LOOP_EN, 32'h0);
        loop_on = 1'b0;
        foreach (corner[i])
            run_rate(corner[i]);
        repeat (6)
            run_rate($urandom_range(125000000, 1000));
        wr(`SCG_OFS_REF_FREQ, applied_hz);
        run_rate(32'h0000C350);
        $display("test crystal divider done");
        wr(`SCG_OFS_LOOP_EN, 32'h1);
        loop_on = 1'b1;
        ref_hz = applied_hz;
        run_rate(32'h017D7840);
        wr(`SCG_OFS_REF_FREQ, 32'h000001F4);
        ref_hz = `SCG_REF_MIN_HZ;
        run_rate(32'h00989680);
        wr(`SCG_OFS_REF_FREQ, 32'h0);
        ref_hz = `SCG_INT_REF_HZ;
        run_rate(32'h00989680);
        $display("test reference source done");
        wr(`SCG_OFS_CLKOUT_EN, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({31'h0, ext_conn_oe_b}, 32'h0, 0);
        wr(`SCG_OFS_TERM_EN, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({31'h0, ext_conn_term_en}, 32'h0, 0);
        @(posedge ref_clk);
        drive_ext <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({30'h0, ext_conn_oe_b, ext_conn_term_en}, 32'h3, 0);
        rd(`SCG_OFS_TERM_EN, v);
        chk(v, 32'h1, 0);
        $display("test connector done");
        test_done();
    end
endmodule
`default_nettype wire
